// [sscs_pkg.sv]
package sscs_pkg;
   localparam int SSCS_DW = 14;
   localparam int SSCS_NCH = 4;
   localparam int SSCS_CLK_MHZ = 200;
   // conversion time per channel in nanoseconds
   localparam int SSCS_CONV_NS = 2500;
   localparam int SSCS_CONV_CYC = (SSCS_CONV_NS * SSCS_CLK_MHZ) / 1000;
   // acquisition time in nanoseconds, least time so round up
   localparam int SSCS_ACQ_NS = 350;
   localparam int SSCS_ACQ_CYC = (SSCS_ACQ_NS * SSCS_CLK_MHZ + 999) / 1000;
   // aperture delay in nanoseconds, typical figure
   localparam int SSCS_APER_NS = 15;
   localparam int SSCS_APER_CYC = (SSCS_APER_NS * SSCS_CLK_MHZ + 999) / 1000;
   // external conversion clock divider, unused: a conversion tick comes on every external clock rising edge
   localparam int SSCS_EXT_DIV = 4;
   localparam logic [3:0] SSCS_SEL_RST = 4'h0;
   localparam logic [13:0] SSCS_DATA_RST = 14'h0000;
   localparam int SSCS_CW = 10;
endpackage

// [sscs_if.sv]
`timescale 1ns/100ps
interface sscs_if;
   import sscs_pkg::*;
   logic convert_trigger;
   logic [3:0] channel_pick_pins;
   logic chip_sel_n;
   logic rd_n;
   logic wr_n;
   logic [13:0] data_dev_o;
   logic data_dev_oe;
   logic [3:0] low_data_lines_host_o;
   logic low_data_lines_host_oe;
   logic busy;
   logic chan_done_n;
   logic [13:0] data_bus;
   // resolved bus level: device drives all 14 lines, host only the low 4
   assign data_bus = data_dev_oe ? data_dev_o
                   : {10'h000, (low_data_lines_host_oe ? low_data_lines_host_o : 4'h0)};
   modport dev (
      input convert_trigger, channel_pick_pins, chip_sel_n, rd_n, wr_n, data_bus,
      output data_dev_o, data_dev_oe, busy, chan_done_n
   );
   modport host (
      output convert_trigger, channel_pick_pins, chip_sel_n, rd_n, wr_n,
      output low_data_lines_host_o, low_data_lines_host_oe,
      input data_bus, busy, chan_done_n
   );
endinterface

// [sscs_dev.sv]
// Implementation choices: strobed register access to a single selection register with no address.
`timescale 1ns/100ps
module sscs_dev
   import sscs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   sscs_if.dev link,
   input wire logic clock_source_select,
   input wire logic external_clock_in,
   input wire logic [55:0] sample_in,
   output logic [3:0] hold_active,
   output logic [1:0] conv_channel
);
   typedef enum {ST_IDLE, ST_APER, ST_CONV, ST_NEXT} sscs_st_t;
   typedef struct packed {
      logic [1:0] trg_s;
      logic trg_d;
      logic [1:0] clk_s;
      logic clk_d;
      logic [1:0] src_s;
      logic [3:0] chsel;
      logic [3:0] latched;
      logic [1:0] chan;
      logic [SSCS_CW-1:0] cnt;
      logic [SSCS_NCH-1:0][SSCS_DW-1:0] held;
      logic [13:0] result;
      logic [13:0] dout;
      logic busy;
      logic done_n;
      logic [3:0] hold;
      logic wr_d;
      sscs_st_t st;
   } sscs_dev_t;
   sscs_dev_t s_r;
   sscs_dev_t s_nxt;
   logic trg_rise;
   logic tick;
   logic wr_edge;
   logic rd_open;
   logic conv_end;
   logic src_reg;
   logic [3:0] pick_now;
   logic [1:0] first_ch;
   logic found;
   logic last_ch;
   logic [13:0] samp;

   // edge detectors on the synchronised start, clock and the write strobe
   always_comb begin
      trg_rise = s_r.trg_s[1] & ~s_r.trg_d;
      wr_edge = ~link.chip_sel_n & ~link.wr_n & ~s_r.wr_d;
      rd_open = ~link.chip_sel_n & ~link.rd_n;
      // internal oscillator is ref_clk itself; external uses rising edges
      tick = s_r.src_s[1] ? (s_r.clk_s[1] & ~s_r.clk_d) : 1'b1;
      conv_end = tick && (s_r.cnt == SSCS_CW'(SSCS_CONV_CYC - 1));
   end

   // selection source mux; the select pin is read only after its synchroniser
   always_comb begin
      src_reg = s_r.src_s[1];
      pick_now = src_reg ? s_r.chsel : link.channel_pick_pins;
   end

   // lowest channel still marked; finished channels drop out of the mask
   always_comb begin
      found = 1'b0;
      first_ch = 2'd0;
      for (int i = SSCS_NCH-1; i >= 0; i--) begin
         if (s_r.latched[i]) begin
            found = 1'b1;
            first_ch = 2'(i);
         end
      end
      // current channel is the last one when no other bit is left
      last_ch = ((s_r.latched & ~(4'h1 << s_r.chan)) == 4'h0);
      // the held copy is converted, so input changes after hold do not leak in
      samp = s_r.held[s_r.chan];
   end

   // sequence control and register write
   always_comb begin
      s_nxt = s_r;
      s_nxt.trg_s = {s_r.trg_s[0], link.convert_trigger};
      s_nxt.trg_d = s_r.trg_s[1];
      s_nxt.clk_s = {s_r.clk_s[0], external_clock_in};
      s_nxt.clk_d = s_r.clk_s[1];
      s_nxt.src_s = {s_r.src_s[0], clock_source_select};
      s_nxt.wr_d = ~link.chip_sel_n & ~link.wr_n;
      s_nxt.done_n = 1'b1;
      // host write of channel selection on the low lines, bit0 is channel 1
      if (wr_edge) begin
         s_nxt.chsel = link.data_bus[3:0];
      end
      unique case (s_r.st)
         ST_IDLE: begin
            // only idle looks at the start edge, so a running sequence is safe
            if (trg_rise) begin
               s_nxt.latched = pick_now;
               s_nxt.busy = 1'b1;
               s_nxt.cnt = '0;
               s_nxt.st = ST_APER;
            end
         end
         ST_APER: begin
            // aperture delay, one shared count keeps the four holds matched
            s_nxt.cnt = s_r.cnt + SSCS_CW'(1);
            if (s_r.cnt == SSCS_CW'(SSCS_APER_CYC - 1)) begin
               // all four stages take their sample on the same cycle
               for (int i = 0; i < SSCS_NCH; i++) begin
                  s_nxt.hold[i] = 1'b1;
                  s_nxt.held[i] = sample_in[i*SSCS_DW +: SSCS_DW];
               end
               s_nxt.st = ST_NEXT;
            end
         end
         ST_NEXT: begin
            // one idle cycle between channels to pick the next marked one
            if (found) begin
               s_nxt.chan = first_ch;
               s_nxt.cnt = '0;
               s_nxt.st = ST_CONV;
            end else begin
               // empty selection ends at once, with no done pulse
               s_nxt.busy = 1'b0;
               s_nxt.hold = 4'h0;
               s_nxt.st = ST_IDLE;
            end
         end
         ST_CONV: begin
            // external clock: count its edges, so the time scales with it
            if (tick) begin
               s_nxt.cnt = s_r.cnt + SSCS_CW'(1);
            end
            if (conv_end) begin
               s_nxt.result = samp;
               s_nxt.done_n = 1'b0;
               s_nxt.latched[s_r.chan] = 1'b0;
               if (last_ch) begin
                  // busy and the final done pulse share one edge
                  s_nxt.busy = 1'b0;
                  s_nxt.hold = 4'h0;
                  s_nxt.st = ST_IDLE;
               end else begin
                  s_nxt.st = ST_NEXT;
               end
            end
         end
      endcase
      // bus copy never changes under an open read; it catches up afterwards
      if (!rd_open) begin
         s_nxt.dout = s_nxt.result;
      end
   end

   // state register; every field resets to a constant
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_r.trg_s <= 2'h0;
         s_r.trg_d <= 1'b0;
         s_r.clk_s <= 2'h0;
         s_r.clk_d <= 1'b0;
         s_r.src_s <= 2'h0;
         s_r.chsel <= SSCS_SEL_RST;
         s_r.latched <= 4'h0;
         s_r.chan <= 2'h0;
         s_r.cnt <= '0;
         s_r.held <= '0;
         s_r.result <= SSCS_DATA_RST;
         s_r.dout <= SSCS_DATA_RST;
         s_r.busy <= 1'b0;
         s_r.done_n <= 1'b1;
         s_r.hold <= 4'h0;
         s_r.wr_d <= 1'b0;
         s_r.st <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // result bus driven while chip select and read are both low
   assign link.data_dev_o = s_r.dout;
   assign link.data_dev_oe = rd_open;
   assign link.busy = s_r.busy;
   assign link.chan_done_n = s_r.done_n;
   // track/hold state per stage, all four switch together
   assign hold_active = s_r.hold;
   assign conv_channel = s_r.chan;
endmodule // sscs_dev

// [sscs_host.sv]
`timescale 1ns/100ps
module sscs_host
   import sscs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   sscs_if.host link,
   input wire logic start_req,
   input wire logic [3:0] pick_in,
   input wire logic wr_req,
   input wire logic [3:0] wr_data,
   output logic [13:0] rd_data,
   output logic rd_valid,
   output logic host_busy
);
   typedef enum {H_IDLE, H_TRIG, H_WR, H_WAIT, H_RD, H_ACQ} sscs_hst_t;
   typedef struct packed {
      logic trig;
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic oe;
      logic [3:0] wd;
      logic [13:0] rd;
      logic rv;
      logic back;
      logic [SSCS_CW-1:0] cnt;
      sscs_hst_t st;
   } sscs_hst_r_t;
   sscs_hst_r_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      // busy and done come from logic on this clock, so they are read directly
      s_nxt.rv = 1'b0;
      unique case (s_r.st)
         H_IDLE: begin
            if (wr_req) begin
               s_nxt.wd = wr_data;
               s_nxt.oe = 1'b1;
               s_nxt.cs_n = 1'b0;
               s_nxt.wr_n = 1'b0;
               s_nxt.back = 1'b0;
               s_nxt.st = H_WR;
            end else if (start_req) begin
               s_nxt.trig = 1'b1;
               s_nxt.cnt = '0;
               s_nxt.st = H_TRIG;
            end
         end
         H_WR: begin
            s_nxt.wr_n = 1'b1;
            s_nxt.oe = 1'b0;
            s_nxt.back = 1'b0;
            if (s_r.back && ~link.chan_done_n) begin
               // a result landed under the write: keep select low and read it
               s_nxt.rd_n = 1'b0;
               s_nxt.st = H_RD;
            end else begin
               s_nxt.cs_n = 1'b1;
               s_nxt.st = s_r.back ? H_WAIT : H_IDLE;
            end
         end
         H_TRIG: begin
            // hold the start high until busy is seen, then drop it
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (link.busy) begin
               s_nxt.trig = 1'b0;
               s_nxt.st = H_WAIT;
            end
         end
         H_WAIT: begin
            // read once per done pulse, never mid conversion
            if (~link.chan_done_n) begin
               s_nxt.cs_n = 1'b0;
               s_nxt.rd_n = 1'b0;
               s_nxt.st = H_RD;
            end else if (~link.busy) begin
               s_nxt.cnt = '0;
               s_nxt.st = H_ACQ;
            end else if (wr_req) begin
               // register writes stay legal mid sequence; they apply next time
               s_nxt.wd = wr_data;
               s_nxt.oe = 1'b1;
               s_nxt.cs_n = 1'b0;
               s_nxt.wr_n = 1'b0;
               s_nxt.back = 1'b1;
               s_nxt.st = H_WR;
            end
         end
         H_RD: begin
            s_nxt.rd = link.data_bus;
            s_nxt.rv = 1'b1;
            s_nxt.cs_n = 1'b1;
            s_nxt.rd_n = 1'b1;
            s_nxt.st = H_WAIT;
         end
         H_ACQ: begin
            // acquisition wait also caps the start rate
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt == SSCS_CW'(SSCS_ACQ_CYC - 1)) begin
               s_nxt.st = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_r <= '{trig: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, oe: 1'b0, wd: 4'h0,
                  rd: SSCS_DATA_RST, rv: 1'b0, back: 1'b0, cnt: '0,
                  st: H_IDLE};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.convert_trigger = s_r.trig;
   assign link.channel_pick_pins = pick_in;
   assign link.chip_sel_n = s_r.cs_n;
   assign link.rd_n = s_r.rd_n;
   assign link.wr_n = s_r.wr_n;
   assign link.low_data_lines_host_o = s_r.wd;
   assign link.low_data_lines_host_oe = s_r.oe;
   assign rd_data = s_r.rd;
   assign rd_valid = s_r.rv;
   assign host_busy = (s_r.st != H_IDLE);
endmodule // sscs_host

// [sscs_assertions.sv]
`timescale 1ns/100ps
module sscs_chk
   import sscs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic convert_trigger,
   input wire logic busy,
   input wire logic chan_done_n,
   input wire logic chip_sel_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic data_dev_oe
);
   logic [9:0] cnt_r;
   logic [7:0] idle_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // cycles since the last done or idle; saturates so a slow clock never wraps
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_r <= 10'h000;
         idle_r <= 8'hff;
      end else begin
         cnt_r <= (!chan_done_n || !busy) ? 10'h000 : cnt_r + {9'h000, cnt_r != 10'h3ff};
         idle_r <= busy ? 8'h00 : idle_r + {7'h00, idle_r != 8'hff};
      end
   end
   AST_BUSY_RISE: assert property ($rose(convert_trigger) && !busy |-> ##3 busy)
      else $error("busy late after start");
   AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(convert_trigger, 3))
      else $error("busy rose without start");
   AST_DONE_PULSE: assert property ($fell(chan_done_n) |=> chan_done_n)
      else $error("done pulse too long");
   AST_DONE_IN_SEQ: assert property ($fell(chan_done_n) |-> $past(busy))
      else $error("done outside sequence");
   AST_LAST_DONE: assert property ($fell(busy) && cnt_r > 10'h0ff |-> !chan_done_n)
      else $error("busy fell apart from done");
   AST_CONV_TIME: assert property ($fell(chan_done_n) |-> cnt_r >= SSCS_CONV_CYC - 1)
      else $error("conversion too short");
   AST_READ_OE: assert property (data_dev_oe == (!chip_sel_n && !rd_n))
      else $error("bus drive mismatch");
   AST_READ_SLOT: assert property ($fell(rd_n) |-> cnt_r < 10'h008)
      else $error("read during conversion");
   AST_WRITE_CYCLE: assert property (!wr_n |-> !chip_sel_n && !data_dev_oe)
      else $error("bad write cycle");
   AST_ACQ_WAIT: assert property ($rose(convert_trigger) |-> idle_r >= SSCS_ACQ_CYC - 2)
      else $error("start before acquisition");
endmodule // sscs_chk

// [test_simultaneous_sample_conversion_sequencer.sv]
`timescale 1ns/100ps
module test_simultaneous_sample_conversion_sequencer;
   import sscs_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic css = 1'b0;
   logic ext_clk = 1'b0;
   logic [55:0] sample = 56'h0;
   logic start_req = 1'b0;
   logic [3:0] pick = 4'h0;
   logic wr_req = 1'b0;
   logic [3:0] wr_data = 4'h0;
   logic [13:0] rd_data;
   logic rd_valid;
   logic host_busy;
   logic [3:0] hold;
   logic [1:0] conv_ch;
   logic [31:0] lf = 32'h4add;
   logic [13:0] got[$];
   int bad_count = 0;
   int num_checks = 0;
   sscs_if link_if();
   sscs_dev sscs_dev_inst(.ref_clk(ref_clk), .reset(reset), .link(link_if),
      .clock_source_select(css), .external_clock_in(ext_clk), .sample_in(sample),
      .hold_active(hold), .conv_channel(conv_ch));
   sscs_host sscs_host_inst(.ref_clk(ref_clk), .reset(reset), .link(link_if),
      .start_req(start_req), .pick_in(pick), .wr_req(wr_req), .wr_data(wr_data),
      .rd_data(rd_data), .rd_valid(rd_valid), .host_busy(host_busy));
   sscs_chk sscs_chk_inst(.ref_clk(ref_clk), .reset(reset),
      .convert_trigger(link_if.convert_trigger), .busy(link_if.busy),
      .chan_done_n(link_if.chan_done_n), .chip_sel_n(link_if.chip_sel_n),
      .rd_n(link_if.rd_n), .wr_n(link_if.wr_n), .data_dev_oe(link_if.data_dev_oe));
   always #2.5 ref_clk = ~ref_clk;
   // free-running conversion clock, unrelated in phase to ref_clk
   always #7.3 ext_clk = ~ext_clk;
   // results as the host hands them out
   always @(posedge ref_clk) if (rd_valid === 1'b1) got.push_back(rd_data);
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // highest marked channel, the one converted last
   function automatic int top_ch(input logic [3:0] s);
      int t;
      t = 0;
      for (int c = 0; c < SSCS_NCH; c++) begin
         if (s[c]) t = c;
      end
      return t;
   endfunction
   task stop_test;
      if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("Error %0t: got %h exp %h", $time, s, e);
      end
   endtask
   // one sequence; the unused source always holds the inverse selection
   task automatic seq(input logic [3:0] sel, input logic m);
      logic [13:0] exp_q[$];
      int n;
      int k;
      @(posedge ref_clk);
      lf = lfsr(lf);
      sample <= {lf[23:0], lfsr(lf)};
      css <= m;
      pick <= m ? ~sel : sel;
      wr_data <= m ? sel : ~sel;
      wr_req <= 1'b1;
      @(posedge ref_clk);
      wr_req <= 1'b0;
      for (int c = 0; c < SSCS_NCH; c++) begin
         if (sel[c]) exp_q.push_back(sample[c*14 +: 14]);
      end
      k = exp_q.size();
      got.delete();
      // host spends one cycle closing the write before it takes a start
      @(posedge ref_clk);
      start_req <= 1'b1;
      @(posedge ref_clk);
      start_req <= 1'b0;
      n = 0;
      while (hold === 4'h0 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      if (sel != 4'h0) chk(32'(hold), 32'hf);
      // disturb every source the latched sequence must no longer see
      lf = lfsr(lf);
      sample <= {lf[23:0], lfsr(lf)};
      pick <= ~pick;
      wr_data <= ~wr_data;
      wr_req <= 1'b1;
      @(posedge ref_clk);
      wr_req <= 1'b0;
      n = 0;
      while (link_if.busy !== 1'b0 && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      if (!m) chk(32'(n >= k * SSCS_CONV_CYC - 5 && n <= k * SSCS_CONV_CYC + 10), 32'h1);
      if (sel != 4'h0) chk(32'(conv_ch), 32'(top_ch(sel)));
      n = 0;
      while (host_busy !== 1'b0 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(hold), 32'h0);
      chk(32'(got.size()), 32'(k));
      foreach (exp_q[i]) chk(32'(got[i]), 32'(exp_q[i]));
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      chk(32'(link_if.busy), 32'h0);
      chk(32'(link_if.chan_done_n), 32'h1);
      seq(4'hf, 1'b0);
      seq(4'h9, 1'b0);
      seq(4'h0, 1'b0);
      seq(4'h8, 1'b1);
      seq(4'hf, 1'b1);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         seq(lf[3:0], lf[4]);
      end
      stop_test;
   end
   // watchdog sized well past the longest expected run
   initial begin
      repeat (95000) @(posedge ref_clk);
      bad_count++;
      stop_test;
   end
endmodule // test_simultaneous_sample_conversion_sequencer
